// ==== common/rsq_defines.svh ====
// Constants of the reset and interrupt sequencer: offsets, fields, resets, counts.
// Assumes an 8-bit core with a 13-bit program counter and an APB host.
// Function
// (RULE1) Reset aborts the current instruction immediately
// (RULE2) Reset clears every port direction bit
// (RULE3) Reset loads stack pointer with FF
// (RULE4) Reset sets mask, clears external latch
// (RULE5) Reset clears prescaler, presets counter, clears enables
// (RULE6) Reset clears stop and wait latches
// (RULE7) Reset vector fetched from 1FFE, 1FFF
// (RULE8) Power-up holds 4064 cycles, then pin
// (RULE9) Reset pin is input only
// (RULE10) Other party holds pin low 1.5 cycles
// (RULE11) Interrupts wait for the instruction boundary
// (RULE12) Falling pin with clear mask sets latch
// (RULE13) Timer request is flag and enable
// (RULE14) Push pc low, pc high, X, A, codes
// (RULE15) Return pulls codes, A, X, pc high, low
// (RULE16) External request beats timer request
// (RULE17) Software trap ignores mask, vector 1FFC
// (RULE18) External vector at 1FFA and 1FFB
// (RULE19) Timer sources share vector 1FF8, 1FF9
// (RULE20) Latch cleared during vector fetch
// (RULE21) Edge or edge-plus-level trigger at build
// (RULE22) Stack in top 64 bytes, push decrements
// (RULE23) Pins pass two-stage synchroniser first
`ifndef RSQ_DEFINES_SVH
`define RSQ_DEFINES_SVH
// Register byte offsets on APB
`define RSQ_OFS_CTRL 12'h000
`define RSQ_OFS_TCTRL 12'h004
`define RSQ_OFS_DDR 12'h008
`define RSQ_OFS_STATUS 12'h00C
// Timer control fields
`define RSQ_TC_CAP_EN 7
`define RSQ_TC_CMP_EN 6
`define RSQ_TC_OVF_EN 5
`define RSQ_TC_CMP_OUT 2
`define RSQ_TC_LEVEL 0
// Condition code mask position
`define RSQ_CODES_MASK_BIT 3
// Reset values
`define RSQ_SP_RESET 8'hFF
`define RSQ_STACK_TOP 2'b11
`define RSQ_TIMER_PRESET 16'hFFFC
// Vector addresses (high byte; low byte follows)
`define RSQ_VEC_RESET 13'h1FFE
`define RSQ_VEC_TRAP 13'h1FFC
`define RSQ_VEC_EXT 13'h1FFA
`define RSQ_VEC_TMR 13'h1FF8
// Power-up stabilisation, in internal clock cycles
`define RSQ_POR_CYCLES 12'hFE0
`endif

// ==== common/rsq_pkg.sv ====
// Types of the reset and interrupt sequencer.
// Assumes rsq_defines.svh holds the numbers.
package rsq_pkg;
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_RST = 5'h01,
    ST_RUN = 5'h02,
    ST_PUSH = 5'h04,
    ST_VEC = 5'h08,
    ST_PULL = 5'h10
  } rsq_state_t;
  // Source of the vector being fetched
  typedef enum logic [1:0] {
    SRC_RESET = 2'h0,
    SRC_TRAP = 2'h1,
    SRC_EXT = 2'h2,
    SRC_TMR = 2'h3
  } rsq_src_t;
endpackage

// ==== verilog/rsq_sequencer.sv ====
// Reset and interrupt sequencer: reset hold, stacking, unstacking, vectors.
// Assumes a core that pauses while cpu_hold_o is high and an async-read memory.
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`include "rsq_defines.svh"
module rsq_sequencer import rsq_pkg::*; #(
  parameter int DDR_W = 20, // Implemented direction bits
  parameter bit LEVEL_TRIG = 1'b1, // Edge-plus-level trigger when set
  parameter logic [11:0] POR_CYCLES = `RSQ_POR_CYCLES // Power-up hold
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic rst_pin_n_i,
  input wire logic irq_pin_n_i,
  input wire logic instr_done_i,
  input wire logic software_trap_instr_i,
  input wire logic return_from_trap_instr_i,
  input wire logic cli_i,
  input wire logic sei_i,
  input wire logic stop_i,
  input wire logic wait_i,
  input wire logic [12:0] pc_i,
  input wire logic [7:0] x_i,
  input wire logic [7:0] a_i,
  input wire logic [7:0] condition_codes_i,
  input wire logic capture_flag_i,
  input wire logic compare_flag_i,
  input wire logic overflow_flag_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [12:0] mem_addr_o,
  output logic [7:0] mem_wdata_o,
  output logic mem_wr_o,
  output logic mem_rd_o,
  output logic cpu_abort_o,
  output logic cpu_hold_o,
  output logic pc_load_o,
  output logic [12:0] pc_o,
  output logic restore_o,
  output logic [2:0] restore_sel_o,
  output logic [7:0] restore_data_o,
  output logic mask_o,
  output logic [7:0] sp_o,
  output logic [DDR_W-1:0] ddr_o,
  output logic timer_clear_o,
  output logic timer_load_o,
  output logic [15:0] timer_preset_o,
  output logic capture_irq_enable_o,
  output logic compare_irq_enable_o,
  output logic overflow_irq_enable_o,
  output logic output_level_o,
  output logic compare_output_o,
  output logic stop_latch_o,
  output logic wait_latch_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);

  // Whole state of the block
  typedef struct packed {
    logic rst_s1; // Reset pin, first stage
    logic rst_s2; // Reset pin, second stage
    logic irq_s1; // Interrupt pin, first stage
    logic irq_s2; // Interrupt pin, second stage
    logic irq_d; // Delayed copy for edge detect
    logic [11:0] por_cnt; // Power-up hold counter
    rsq_state_t state; // Sequencer state
    rsq_src_t src; // Vector source
    logic [2:0] step; // Step within a sequence
    logic [7:0] sp; // Stack pointer
    logic mask; // Global interrupt mask
    logic ext_latch; // External request latch
    logic [7:0] hi_byte; // Captured high byte
    logic [12:0] pc; // Program counter to load
    logic pc_load; // Load strobe
    logic restore; // Restore strobe
    logic [2:0] restore_sel; // Restored register index
    logic [7:0] restore_data; // Restored byte
    logic [12:0] mem_addr; // Memory address
    logic [7:0] mem_wdata; // Memory write data
    logic mem_wr; // Memory write
    logic mem_rd; // Memory read
    logic [DDR_W-1:0] ddr; // Port direction bits
    logic [7:0] tctrl; // Timer control bits
    logic stop_latch; // Clocks stopped
    logic wait_latch; // Core waiting
    logic ack; // APB answer pending
    logic [31:0] prdata; // APB read data
    logic slverr; // APB error
  } rsq_regs_t;

  rsq_regs_t r_reg;
  rsq_regs_t r_next;
  logic int_rst; // Internal reset condition
  logic tmr_req; // Qualified-by-enable timer request
  logic ext_pend; // External request pending
  logic ext_fall; // Falling edge of interrupt pin
  logic apb_done; // APB access completes this edge
  logic apb_hit; // Address maps to a register
  logic [31:0] rd_mux; // Read data selection
  logic [12:0] vec_base; // Vector address for source
  // Request terms and decode
  always_comb begin
    // (RULE8) POR hold, pin extends
    int_rst = (r_reg.por_cnt != POR_CYCLES) || !r_reg.rst_s2;
    // (RULE13) Timer flag and enable
    tmr_req = (capture_flag_i && r_reg.tctrl[`RSQ_TC_CAP_EN])
      || (compare_flag_i && r_reg.tctrl[`RSQ_TC_CMP_EN])
      || (overflow_flag_i && r_reg.tctrl[`RSQ_TC_OVF_EN]);
    // (RULE12) Edge seen after sync
    ext_fall = r_reg.irq_d && !r_reg.irq_s2;
    // (RULE21) Level option keeps pending
    ext_pend = r_reg.ext_latch || (LEVEL_TRIG && !r_reg.irq_s2);
    apb_done = psel_i && penable_i && r_reg.ack;
    apb_hit = (paddr_i == `RSQ_OFS_CTRL) || (paddr_i == `RSQ_OFS_TCTRL)
      || (paddr_i == `RSQ_OFS_DDR) || (paddr_i == `RSQ_OFS_STATUS);
    // (RULE19) One vector for timer sources
    case (r_reg.src)
      SRC_RESET: vec_base = `RSQ_VEC_RESET;
      SRC_TRAP: vec_base = `RSQ_VEC_TRAP;
      SRC_EXT: vec_base = `RSQ_VEC_EXT;
      default: vec_base = `RSQ_VEC_TMR;
    endcase
    case (paddr_i)
      `RSQ_OFS_CTRL: rd_mux = {31'h0, r_reg.mask};
      `RSQ_OFS_TCTRL: rd_mux = {24'h0, r_reg.tctrl};
      `RSQ_OFS_DDR: rd_mux = 32'(r_reg.ddr);
      `RSQ_OFS_STATUS: rd_mux = {11'h0, r_reg.state, r_reg.sp, 2'h0,
        r_reg.wait_latch, r_reg.stop_latch, r_reg.mask, tmr_req,
        ext_pend, int_rst};
      default: rd_mux = 32'h0;
    endcase
  end

  // Next state of every register
  always_comb begin
    r_next = r_reg;
    r_next.pc_load = 1'b0;
    r_next.restore = 1'b0;
    r_next.mem_wr = 1'b0;
    r_next.mem_rd = 1'b0;
    // (RULE23) Two-stage pin synchronisers
    r_next.rst_s1 = rst_pin_n_i;
    r_next.rst_s2 = r_reg.rst_s1;
    r_next.irq_s1 = irq_pin_n_i;
    r_next.irq_s2 = r_reg.irq_s1;
    r_next.irq_d = r_reg.irq_s2;
    if (r_reg.por_cnt != POR_CYCLES) begin
      r_next.por_cnt = r_reg.por_cnt + 12'd1;
    end
    // CPU mask instructions and low-power latches
    if (cli_i) begin
      r_next.mask = 1'b0;
    end
    if (sei_i) begin
      r_next.mask = 1'b1;
    end
    if (stop_i) begin
      r_next.stop_latch = 1'b1;
      r_next.mask = 1'b0;
      r_next.tctrl[`RSQ_TC_CAP_EN] = 1'b0;
      r_next.tctrl[`RSQ_TC_CMP_EN] = 1'b0;
      r_next.tctrl[`RSQ_TC_OVF_EN] = 1'b0;
    end
    if (wait_i) begin
      r_next.wait_latch = 1'b1;
      r_next.mask = 1'b0;
    end
    // APB write takes effect on the answering edge
    if (apb_done && pwrite_i) begin
      case (paddr_i)
        `RSQ_OFS_CTRL: r_next.mask = pwdata_i[0];
        `RSQ_OFS_TCTRL: r_next.tctrl = pwdata_i[7:0] & 8'hE5;
        `RSQ_OFS_DDR: r_next.ddr = pwdata_i[DDR_W-1:0];
        default: r_next.tctrl = r_reg.tctrl;
      endcase
    end
    // APB answer one cycle into the access phase
    r_next.ack = psel_i && penable_i && !r_reg.ack;
    if (psel_i && penable_i && !r_reg.ack) begin
      r_next.prdata = pwrite_i ? 32'h0 : rd_mux;
      r_next.slverr = !apb_hit;
    end
    // Sequencer
    case (r_reg.state)
      ST_RST: begin
        // (RULE7) Leave reset into vector fetch
        if (!int_rst) begin
          r_next.state = ST_VEC;
          r_next.src = SRC_RESET;
          r_next.step = 3'd0;
        end
      end
      ST_RUN: begin
        // (RULE11) Checked only at boundaries
        if (instr_done_i) begin
          r_next.step = 3'd0;
          if (return_from_trap_instr_i) begin
            r_next.state = ST_PULL;
          // (RULE17) Trap ignores mask
          end else if (software_trap_instr_i) begin
            r_next.state = ST_PUSH;
            r_next.src = SRC_TRAP;
          // (RULE16) External before timer
          end else if (ext_pend && !r_reg.mask) begin
            r_next.state = ST_PUSH;
            r_next.src = SRC_EXT;
          end else if (tmr_req && !r_reg.mask) begin
            r_next.state = ST_PUSH;
            r_next.src = SRC_TMR;
          end
        end
      end
      ST_PUSH: begin
        // (RULE14) Push pc low, high, X, A, codes
        r_next.mem_wr = 1'b1;
        r_next.mem_addr = {5'h00, r_reg.sp};
        case (r_reg.step)
          3'd0: r_next.mem_wdata = pc_i[7:0];
          3'd1: r_next.mem_wdata = {3'h0, pc_i[12:8]};
          3'd2: r_next.mem_wdata = x_i;
          3'd3: r_next.mem_wdata = a_i;
          default: r_next.mem_wdata = condition_codes_i;
        endcase
        // (RULE22) Decrement within top 64
        r_next.sp = {`RSQ_STACK_TOP, r_reg.sp[5:0] - 6'h01};
        r_next.step = r_reg.step + 3'd1;
        if (r_reg.step == 3'd4) begin
          // (RULE14) Mask set before vector
          r_next.mask = 1'b1;
          r_next.wait_latch = 1'b0;
          if (r_reg.src == SRC_EXT) begin
            r_next.stop_latch = 1'b0;
          end
          r_next.state = ST_VEC;
          r_next.step = 3'd0;
        end
      end
      ST_VEC: begin
        // (RULE18) Vector from source table
        if (r_reg.step != 3'd2) begin
          r_next.mem_rd = 1'b1;
          r_next.mem_addr = vec_base + 13'(r_reg.step);
        end
        if (r_reg.step == 3'd1) begin
          r_next.hi_byte = mem_rdata_i;
        end
        // (RULE20) Latch cleared on fetch
        if (r_reg.step == 3'd0 && r_reg.src == SRC_EXT) begin
          r_next.ext_latch = 1'b0;
        end
        r_next.step = r_reg.step + 3'd1;
        if (r_reg.step == 3'd2) begin
          r_next.pc = {r_reg.hi_byte[4:0], mem_rdata_i};
          r_next.pc_load = 1'b1;
          r_next.state = ST_RUN;
          r_next.step = 3'd0;
        end
      end
      ST_PULL: begin
        // (RULE22) Increment before each pull
        if (r_reg.step != 3'd5) begin
          r_next.mem_rd = 1'b1;
          r_next.sp = {`RSQ_STACK_TOP, r_reg.sp[5:0] + 6'h01};
          r_next.mem_addr = {5'h00, `RSQ_STACK_TOP, r_reg.sp[5:0] + 6'h01};
        end
        // (RULE15) Pull codes, A, X, pc high, low
        if (r_reg.step != 3'd0) begin
          r_next.restore = 1'b1;
          r_next.restore_sel = r_reg.step - 3'd1;
          r_next.restore_data = mem_rdata_i;
        end
        if (r_reg.step == 3'd1) begin
          r_next.mask = mem_rdata_i[`RSQ_CODES_MASK_BIT];
        end
        if (r_reg.step == 3'd4) begin
          r_next.hi_byte = mem_rdata_i;
        end
        r_next.step = r_reg.step + 3'd1;
        if (r_reg.step == 3'd5) begin
          r_next.pc = {r_reg.hi_byte[4:0], mem_rdata_i};
          r_next.pc_load = 1'b1;
          r_next.state = ST_RUN;
          r_next.step = 3'd0;
        end
      end
      default: r_next.state = ST_RST;
    endcase
    // (RULE12) Latch on edge, clear mask
    if (ext_fall && !r_reg.mask) begin
      r_next.ext_latch = 1'b1;
    end
    // (RULE1) Internal reset aborts at once
    if (int_rst) begin
      r_next.state = ST_RST;
      r_next.step = 3'd0;
      r_next.mem_wr = 1'b0;
      r_next.mem_rd = 1'b0;
      r_next.pc_load = 1'b0;
      r_next.restore = 1'b0;
      // (RULE2) Direction bits cleared
      r_next.ddr = '0;
      // (RULE3) Stack pointer reset
      r_next.sp = `RSQ_SP_RESET;
      // (RULE4) Mask set, latch cleared
      r_next.mask = 1'b1;
      r_next.ext_latch = 1'b0;
      // (RULE5) Timer enables and outputs cleared
      r_next.tctrl = 8'h00;
      // (RULE6) Stop and wait released
      r_next.stop_latch = 1'b0;
      r_next.wait_latch = 1'b0;
    end
  end

  // Register the state; sys_rst_i is the power-on reset
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      r_reg <= '0;
      r_reg.state <= ST_RST;
      r_reg.sp <= `RSQ_SP_RESET;
      r_reg.mask <= 1'b1;
    end else begin
      r_reg <= r_next;
    end
  end

  // Outputs
  assign mem_addr_o = r_reg.mem_addr;
  assign mem_wdata_o = r_reg.mem_wdata;
  assign mem_wr_o = r_reg.mem_wr;
  assign mem_rd_o = r_reg.mem_rd;
  // (RULE9) Reset pin only sensed
  assign cpu_abort_o = (r_reg.state == ST_RST);
  assign cpu_hold_o = (r_reg.state != ST_RUN);
  assign pc_load_o = r_reg.pc_load;
  assign pc_o = r_reg.pc;
  assign restore_o = r_reg.restore;
  assign restore_sel_o = r_reg.restore_sel;
  assign restore_data_o = r_reg.restore_data;
  assign mask_o = r_reg.mask;
  assign sp_o = r_reg.sp;
  assign ddr_o = r_reg.ddr;
  // (RULE5) Prescaler cleared, counter preset
  assign timer_clear_o = cpu_abort_o;
  assign timer_load_o = cpu_abort_o;
  assign timer_preset_o = `RSQ_TIMER_PRESET;
  assign capture_irq_enable_o = r_reg.tctrl[`RSQ_TC_CAP_EN];
  assign compare_irq_enable_o = r_reg.tctrl[`RSQ_TC_CMP_EN];
  assign overflow_irq_enable_o = r_reg.tctrl[`RSQ_TC_OVF_EN];
  assign output_level_o = r_reg.tctrl[`RSQ_TC_LEVEL];
  assign compare_output_o = r_reg.tctrl[`RSQ_TC_CMP_OUT];
  assign stop_latch_o = r_reg.stop_latch;
  assign wait_latch_o = r_reg.wait_latch;
  assign prdata_o = r_reg.prdata;
  assign pready_o = psel_i && penable_i && r_reg.ack;
  assign pslverr_o = pready_o && r_reg.slverr;

  // Reset pin low reaches abort within three cycles
  rst_abort_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE1
    !r_reg.rst_s2 |=> cpu_abort_o)
    else $error("reset pin did not abort");
  // Reset forces stack pointer, mask, latch, directions
  rst_values_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE3
    cpu_abort_o && $past(cpu_abort_o) |-> sp_o == 8'hFF && mask_o
      && !r_reg.ext_latch && ddr_o == '0)
    else $error("reset values wrong");
  // Power-up hold keeps abort
  por_hold_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE8
    r_reg.por_cnt < POR_CYCLES |-> cpu_abort_o)
    else $error("left reset before power-up hold");
  // Push writes five bytes back to back
  push_five_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE14
    $rose(r_reg.state == ST_PUSH) |=> mem_wr_o [*5] ##1 !mem_wr_o && mask_o)
    else $error("push sequence wrong");
  // Push decrements stack pointer
  push_sp_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE22
    mem_wr_o |-> sp_o[5:0] == mem_addr_o[5:0] - 6'h01 && sp_o[7:6] == 2'b11)
    else $error("stack pointer not decremented");
  // External wins over timer at boundary
  ext_first_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE16
    r_reg.state == ST_RUN && instr_done_i && !return_from_trap_instr_i
      && !software_trap_instr_i && ext_pend && !mask_o && !int_rst |=> r_reg.src == SRC_EXT)
    else $error("external request not first");
  // External vector address
  ext_vec_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE18
    r_reg.state == ST_VEC && r_reg.step == 3'd0 && r_reg.src == SRC_EXT && !int_rst
      |=> mem_rd_o && mem_addr_o == 13'h1FFA ##1 mem_addr_o == 13'h1FFB)
    else $error("external vector address wrong");
  // Latch clear at fetch unless a new edge
  ext_clr_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE20
    r_reg.state == ST_VEC && r_reg.step == 3'd0 && r_reg.src == SRC_EXT
      && !ext_fall |=> !r_reg.ext_latch)
    else $error("latch not cleared on fetch");
  // Pull restores select 0 first, then select 4 with the load four cycles later
  pull_five_a: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // RULE15
    $rose(r_reg.state == ST_PULL) |=> ##1 restore_o && restore_sel_o == 3'd0
      ##4 restore_o && restore_sel_o == 3'd4 && pc_load_o ##1 !restore_o)
    else $error("pull order wrong");

endmodule // rsq_sequencer

// ==== testbench/rsq_mem_model.sv ====
// Memory behind the sequencer: vector bytes, stack RAM and an async read port.
// Assumes one-cycle registered read and write strobes from the sequencer.
module rsq_mem_model (
  input wire logic clk_i,
  input wire logic [12:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [8192]; // Whole 8K byte space
  // Vectors: reset 0100, trap 0200, external 0300, timer 0400
  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    mem[13'h1FFE] = 8'h01;
    mem[13'h1FFC] = 8'h02;
    mem[13'h1FFA] = 8'h03;
    mem[13'h1FF8] = 8'h04;
  end
  // Data only while strobed; otherwise the addressed byte inverted
  assign rdata_o = rd_i ? mem[addr_i] : ~mem[addr_i];
  // Stack writes land on the clock edge
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[addr_i] <= wdata_i;
    end
  end
endmodule // rsq_mem_model

// ==== testbench/tb_top.sv ====
// Bench for the reset and interrupt sequencer: APB, core boundaries, pins.
// Assumes the memory model answers reads at once and the core waits while held.
`include "rsq_defines.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] POR = 12'h008; // Short power-up hold
  logic clk, rst, rst_n, irq_n, done, trap_v, ret_v, cli, sei, stp, wt;
  logic cap_f, cmp_f, ovf_f, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [12:0] core_pc, m_addr, pc_o;
  logic [7:0] core_x, core_a, core_cc, m_wd, m_rd, rdat, sp;
  logic m_wr, m_rdy, abort, hold, pc_ld, rest, mask, tclr, tld;
  logic cap_en, cmp_en, ovf_en, out_lvl, cmpo, stopl, waitl, e, got;
  logic [2:0] rsel;
  logic [19:0] ddr;
  logic [15:0] tpre;
  logic [12:0] pcv;
  logic [20:0] wq[$]; // Stack writes seen: address, data
  logic [10:0] rq[$]; // Restores seen: select, data
  logic [7:0] pushed [5] = '{8'hBC, 8'h0A, 8'h5A, 8'hC3, 8'h00};
  int err_total = 0;
  int comparisons = 0;

  rsq_sequencer #(.POR_CYCLES(POR)) rsq_sequencer_i (
    .sys_clk_i(clk), .sys_rst_i(rst), .rst_pin_n_i(rst_n), .irq_pin_n_i(irq_n),
    .instr_done_i(done), .software_trap_instr_i(trap_v),
    .return_from_trap_instr_i(ret_v), .cli_i(cli), .sei_i(sei),
    .stop_i(stp), .wait_i(wt), .pc_i(core_pc), .x_i(core_x), .a_i(core_a),
    .condition_codes_i(core_cc), .capture_flag_i(cap_f), .compare_flag_i(cmp_f),
    .overflow_flag_i(ovf_f), .mem_rdata_i(m_rd), .mem_addr_o(m_addr),
    .mem_wdata_o(m_wd), .mem_wr_o(m_wr), .mem_rd_o(m_rdy), .cpu_abort_o(abort),
    .cpu_hold_o(hold), .pc_load_o(pc_ld), .pc_o(pc_o), .restore_o(rest),
    .restore_sel_o(rsel), .restore_data_o(rdat), .mask_o(mask), .sp_o(sp),
    .ddr_o(ddr), .timer_clear_o(tclr), .timer_load_o(tld), .timer_preset_o(tpre),
    .capture_irq_enable_o(cap_en), .compare_irq_enable_o(cmp_en),
    .overflow_irq_enable_o(ovf_en), .output_level_o(out_lvl),
    .compare_output_o(cmpo), .stop_latch_o(stopl), .wait_latch_o(waitl),
    .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

  rsq_mem_model rsq_mem_model_i (.clk_i(clk), .addr_i(m_addr), .wdata_i(m_wd),
    .wr_i(m_wr), .rd_i(m_rdy), .rdata_o(m_rd));

  // 20 MHz clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Compare one value, report and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic stop_test();
    $display("Counts: %0d comparisons, %0d mismatches", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // One APB transfer; waits for pready, takes data at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    // Waits for the answer; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One-cycle pulse on clear mask, set mask, stop, wait
  task automatic ctl(input logic [3:0] v);
    @(posedge clk);
    {cli, sei, stp, wt} <= v;
    @(posedge clk);
    {cli, sei, stp, wt} <= 4'h0;
  endtask

  // Instruction boundary; records stack traffic until a program counter load
  task automatic bnd(input logic s, input logic r);
    wq.delete();
    rq.delete();
    got = 1'b0;
    @(posedge clk);
    {done, trap_v, ret_v} <= {1'b1, s, r};
    @(posedge clk);
    {done, trap_v, ret_v} <= 3'h0;
    for (int n = 0; n < 40 && !got; n++) begin
      #1;
      if (m_wr === 1'b1) wq.push_back({m_addr, m_wd});
      if (rest === 1'b1) rq.push_back({rsel, rdat});
      if (pc_ld === 1'b1) {got, pcv} = {1'b1, pc_o};
      @(posedge clk);
    end
  endtask

  // Accepted interrupt: stacked bytes, new program counter, mask
  task automatic svc(input string what, input logic s, input logic [12:0] vec);
    bnd(s, 1'b0);
    for (int i = 0; i < 5; i++) chk("push", wq[i], {5'h00, 8'(8'hFF - i), pushed[i]});
    chk(what, {got, pcv}, {1'b1, vec});
    chk("mask set", {mask, sp}, {1'h1, 8'hFA});
  endtask

  // Return: pulled order and stack pointer back at top
  task automatic ret();
    bnd(1'b0, 1'b1);
    for (int i = 0; i < 5; i++) chk("pull", rq[i], {3'(i), pushed[4-i]});
    chk("sp back", sp, 8'hFF);
  endtask

  // Values forced by any reset
  task automatic rst_state();
    chk("abort", abort, 1'h1);
    chk("ddr", ddr, 20'h00000);
    chk("sp", sp, 8'hFF);
    chk("mask", mask, 1'h1);
    chk("timer", {tclr, tld, tpre, cap_en, cmp_en, ovf_en, out_lvl, cmpo}, 23'h7FFF80);
    chk("latches", {stopl, waitl}, 2'h0);
  endtask

  // Wait for the reset vector load, counting cycles
  task automatic boot(output int n);
    n = 0;
    while (pc_ld !== 1'b1 && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("reset vec", pc_o, 13'h0100);
  endtask

  // Watchdog: the tests take under 1500 cycles
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    stop_test();
  end

  initial begin
    int n;
    {rst, rst_n, irq_n, done, trap_v, ret_v, cli, sei, stp, wt} = 10'h380;
    {cap_f, cmp_f, ovf_f, psel, penable, pwrite, paddr, pwdata} = '0;
    {core_pc, core_x, core_a, core_cc} = {13'h0ABC, 8'h5A, 8'hC3, 8'h00};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    rst_state();
    boot(n);
    chk("por hold", n >= POR, 1'h1);
    $display("test reset done");
    apb(1'b1, `RSQ_OFS_DDR, 32'hFFFFFFFF);
    apb(1'b0, `RSQ_OFS_DDR, 32'h00000000);
    chk("ddr rd", {q, ddr}, {32'h000FFFFF, 20'hFFFFF});
    apb(1'b1, `RSQ_OFS_TCTRL, 32'h000000E5);
    #1;
    chk("enables", {cap_en, cmp_en, ovf_en, cmpo, out_lvl}, 5'h1F);
    apb(1'b0, 12'h010, 32'h00000000);
    chk("unmapped", {e, q}, {1'h1, 32'h00000000});
    $display("test apb done");
    ctl(4'h8);
    cap_f <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("no boundary", hold, 1'h0);
    svc("timer vec", 1'b0, 13'h0400);
    ret();
    irq_n <= 1'b0;
    repeat (4) @(posedge clk);
    svc("ext first", 1'b0, 13'h0300);
    ret();
    svc("level again", 1'b0, 13'h0300);
    {irq_n, cap_f} <= 2'b10;
    ret();
    $display("test interrupts done");
    ctl(4'h4);
    svc("trap vec", 1'b1, 13'h0200);
    irq_n <= 1'b0;
    repeat (4) @(posedge clk);
    bnd(1'b0, 1'b0);
    chk("masked", {got, 8'(wq.size())}, 9'h000);
    irq_n <= 1'b1;
    ctl(4'h3);
    #1;
    chk("low power", {stopl, waitl}, 2'h3);
    $display("test trap done");
    // Pin held low well over one and a half cycles
    rst_n <= 1'b0;
    n = 0;
    while (abort !== 1'b1 && n < 8) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("pin abort", n <= 4, 1'h1);
    repeat (20) @(posedge clk);
    #1;
    rst_state();
    apb(1'b0, `RSQ_OFS_STATUS, 32'h00000000);
    chk("latch clr", q[1], 1'h0);
    chk("pin held", abort, 1'h1);
    rst_n <= 1'b1;
    boot(n);
    $display("test pin reset done");
    stop_test();
  end
endmodule // tb_top
